// File: test/pslp_sw_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// monitoring software: apb master that programs the counters
module pslp_sw_model
    import pslp_pkg::*;
(
    // clock
    input  wire logic        clk,
    // apb master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic lastErr;
    initial begin
        {psel, penable, pwrite, paddr, pwdata, lastErr} = '0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // the wait is cut short only by the bench timeout
        do @(posedge clk); while (pready !== 1'b1);
        r       = prdata;
        lastErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic cfg(input int c, input logic [15:0] ev, input logic [31:0] lo,
                       input logic [31:0] hi);
        logic [31:0] r;
        for (int i = 0; i < 4; i++) xfer(1'b1, 8'(4 * i), 32'h0000_0000, r);
        xfer(1'b1, 8'(4 * c), {9'h000, 1'b1, 6'h00, ev}, r);
        xfer(1'b1, OFF_SAMP_LO, lo, r);
        xfer(1'b1, OFF_SAMP_HI, hi, r);
    endtask : cfg
endmodule : pslp_sw_model
`default_nettype wire

// File: test/tb_precise_sampling_latency_store.sv
`timescale 1ns/1ps
`default_nettype none
module tb_precise_sampling_latency_store;
    import pslp_pkg::*;
    logic        clk, rstB, instRetire, psel, penable, pwrite, pready, pslverr;
    logic        ldTagReq, earlyWarn, preciseTrap;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [47:0] a;
    pslp_load_s  ld;
    pslp_store_s st;
    pslp_rec_s   rec, recQ;
    int          errors, cmp_count, cycles, seed, k, lim, cnt, lastLat, recN;
    pslp_top i_dut (.clk(clk), .rst_b(rstB), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ld(ld), .st(st), .instRetire(instRetire),
        .genEvent(4'h0), .ldTagReq(ldTagReq), .earlyWarn(earlyWarn),
        .preciseTrap(preciseTrap), .rec(rec));
    pslp_sw_model i_sw (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ==========================================================
    // checking and closing
    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    always @(posedge clk) begin
        cycles++;
        if (rec.valid === 1'b1) begin
            recN++;
            recQ = rec;
        end
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end
    // ==========================================================
    // core side stimulus
    task automatic load(input int n, input logic [3:0] s, input logic sm, input logic lk);
        ld.dispatch <= 1'b1;
        // untagged dispatches are fine: only the edge with ldTagReq high starts tracking
        do @(posedge clk); while (ldTagReq !== 1'b1);
        ld.dispatch <= 1'b0;
        repeat (n - 1) @(posedge clk);
        ld.go       <= 1'b1;
        @(posedge clk);
        ld.go       <= 1'b0;
        ld.retire   <= 1'b1;
        {ld.source, ld.stlbMiss, ld.lock} <= {s, sm, lk};
        @(posedge clk);
        ld.retire   <= 1'b0;
        if (n > lim) begin
            cnt++;
            lastLat = n;
        end
    endtask : load
    task automatic store(input logic [47:0] ad, input logic [2:0] f);
        {st.addr, st.hit, st.stlbMiss, st.lock, st.retire} <= {ad, f, 1'b1};
        @(posedge clk);
        st.retire <= 1'b0;
    endtask : store
    initial begin
        {rstB, instRetire, ld, st, errors, cmp_count, cycles, recN} = '0;
        seed = 29782;
        repeat (3) @(posedge clk);
        rstB <= 1'b1;
        // ==========================================================
        // apb: unmapped access and counter configuration
        i_sw.xfer(1'b0, 8'h44, 32'h0000_0000, rd);
        check("unmapped err", i_sw.lastErr, 1'b1);
        lim = 3 + ($unsigned($random(seed)) % 4);
        i_sw.cfg(0, EVT_LOAD_LAT, 32'h0000_0001, 32'h0000_0001);
        i_sw.xfer(1'b1, OFF_LAT_LIMIT, lim, rd);
        i_sw.xfer(1'b1, OFF_RELOAD0, 32'hFFFF_FFF0, rd);
        $display("test apb done");
        // ==========================================================
        // load latency: limit boundary, random latencies, cancel
        for (int i = 0; i < 8; i++) begin
            k = (i < 2) ? lim + i : 4 + ($unsigned($random(seed)) % 8);
            load(k, 4'($random(seed)), 1'b0, 1'b1);
            i_sw.xfer(1'b0, OFF_COUNT0, 32'h0000_0000, rd);
            check("count0", rd, cnt);
            i_sw.xfer(1'b0, OFF_LAST_LAT, 32'h0000_0000, rd);
            check("last latency", rd, lastLat);
        end
        ld.dispatch <= 1'b1;
        do @(posedge clk); while (ldTagReq !== 1'b1);
        ld.dispatch <= 1'b0;
        ld.cancel   <= 1'b1;
        @(posedge clk);
        ld.cancel   <= 1'b0;
        @(negedge clk);
        check("tag after cancel", ldTagReq, 1'b1);
        i_sw.xfer(1'b0, OFF_COUNT0, 32'h0000_0000, rd);
        check("count0 cancel", rd, cnt);
        $display("test load latency done");
        // ==========================================================
        // overflow writes a load record
        i_sw.xfer(1'b1, OFF_COUNT0, 32'hFFFF_FFFF, rd);
        load(lim + 2, 4'h9, 1'b1, 1'b0);
        i_sw.xfer(1'b0, OFF_STATUS, 32'h0000_0000, rd);
        check("status", rd[0], 1'b0);
        check("records", recN, 1);
        check("load src", recQ.src, 64'h0000_0000_0000_0019);
        check("load lat", recQ.lat, lim + 2);
        i_sw.xfer(1'b0, OFF_COUNT0, 32'h0000_0000, rd);
        check("reload", rd, 32'hFFFF_FFF0);
        $display("test load record done");
        // ==========================================================
        // precise store on counter 3
        i_sw.cfg(3, EVT_PREC_STORE, 32'h0000_0008, 32'h8000_0000);
        i_sw.xfer(1'b1, OFF_COUNT0 + 8'h0C, 32'hFFFF_FFFF, rd);
        store(48'h0000_1234_5678, 3'b111);
        repeat (3) @(posedge clk);
        check("no store record yet", recN, 1);
        a = {17'h0_0000, 31'($random(seed))};
        store(a, 3'b101);
        repeat (2) @(posedge clk);
        check("store record", recN, 2);
        check("store addr", recQ.addr, {16'h0000, a});
        check("store status", recQ.src, 64'h0000_0000_0000_0021);
        check("store lat", recQ.lat, 64'h0000_0000_0000_0000);
        $display("test precise store done");
        // ==========================================================
        // precise distribution on counter 1
        i_sw.cfg(1, EVT_PREC_DIST, 32'h0000_0002, 32'h0000_0000);
        i_sw.xfer(1'b1, OFF_COUNT0 + 8'h04, 32'hFFFF_FFFE, rd);
        @(negedge clk);
        check("warn early", earlyWarn, 1'b0);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            instRetire <= 1'b1;
            @(posedge clk);
            instRetire <= 1'b0;
            @(negedge clk);
            check("warn", earlyWarn, i == 0);
            check("trap", preciseTrap, i == 1);
        end
        $display("test precise distribution done");
        results();
    end
endmodule : tb_precise_sampling_latency_store
`default_nettype wire

// File: verilog/pslp_counter.sv
`timescale 1ns/1ps
`default_nettype none
module pslp_counter #(
    parameter int W = 32
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // control
    input  wire logic         inc,
    input  wire logic         wrEn,
    input  wire logic [W-1:0] wrVal,
    input  wire logic         reloadEn,
    input  wire logic [W-1:0] reloadVal,
    // status
    output logic [W-1:0]      count,
    output logic              ovf,
    output logic              nearOvf
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    assign nearOvf = (cnt_r == '1);
    assign ovf     = inc & nearOvf & !wrEn;
    assign count   = cnt_r;

    // software write wins over counting in the same cycle
    always_comb begin
        cnt_nxt = cnt_r;
        if (wrEn) begin
            cnt_nxt = wrVal;
        end else if (ovf) begin
            cnt_nxt = reloadEn ? reloadVal : '0;
        end else if (inc) begin
            cnt_nxt = cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    a_reload_after_ovf: assert property (@(posedge clk) disable iff (!rst_b)
        ovf && reloadEn |=> cnt_r == $past(reloadVal)) else $error("no reload");
endmodule : pslp_counter
`default_nettype wire

// File: verilog/pslp_lfsr.sv
`timescale 1ns/1ps
`default_nettype none
module pslp_lfsr #(
    parameter int               W    = 16,
    parameter logic [W-1:0]     TAPS = '1,
    parameter logic [W-1:0]     SEED = '1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // random output
    output logic              rndBit
);
    logic [W-1:0] lfsr_r;
    logic [W-1:0] lfsr_nxt;

    // free running so that tag choice never follows program flow
    always_comb begin
        lfsr_nxt = lfsr_r[0] ? ((lfsr_r >> 1) ^ TAPS) : (lfsr_r >> 1);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lfsr_r <= SEED;
        end else begin
            lfsr_r <= lfsr_nxt;
        end
    end

    assign rndBit = lfsr_r[0];

    a_lfsr_alive: assert property (@(posedge clk) disable iff (!rst_b)
        lfsr_r != '0) else $error("lfsr stuck at zero");
endmodule : pslp_lfsr
`default_nettype wire

// File: verilog/pslp_pkg.sv
package pslp_pkg;

    // ==========================================================
    // event codes (low sixteen bits of an event_select_register)
    localparam logic [15:0] EVT_LOAD_LAT   = 16'h01CD;
    localparam logic [15:0] EVT_PREC_STORE = 16'h02CD;
    localparam logic [15:0] EVT_PREC_DIST  = 16'h01C0;
    localparam int          EVT_EN_BIT     = 22;

    // ==========================================================
    // counters and sampling_enable_register layout
    localparam int NUM_CTR     = 4;
    localparam int CTR_W       = 32;
    localparam int LAT_W       = 16;
    localparam int STORE_CTR   = 3;
    localparam int PDIST_CTR   = 1;
    localparam int LL_EN_LSB   = 32;
    localparam int PS_EN_BIT   = 63;

    // ==========================================================
    // record field positions
    localparam int SRC_STLB_BIT = 4;
    localparam int SRC_LOCK_BIT = 5;
    localparam int ST_HIT_BIT   = 0;

    // ==========================================================
    // apb byte offsets
    localparam logic [7:0] OFF_EVTSEL0   = 8'h00;
    localparam logic [7:0] OFF_SAMP_LO   = 8'h10;
    localparam logic [7:0] OFF_SAMP_HI   = 8'h14;
    localparam logic [7:0] OFF_LAT_LIMIT = 8'h18;
    localparam logic [7:0] OFF_STATUS    = 8'h1C;
    localparam logic [7:0] OFF_COUNT0    = 8'h20;
    localparam logic [7:0] OFF_RELOAD0   = 8'h30;
    localparam logic [7:0] OFF_LAST_LAT  = 8'h40;

    // ==========================================================
    // lfsr reset value and taps
    localparam logic [15:0] RST_LFSR  = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;

    typedef enum logic [0:0] {
        AS_IDLE    = 1'b0,
        AS_WAIT_ST = 1'b1
    } pslp_asst_e;

    typedef struct packed {
        logic        dispatch;
        logic        go;
        logic        retire;
        logic        cancel;
        logic [3:0]  source;
        logic        stlbMiss;
        logic        lock;
        logic [47:0] addr;
    } pslp_load_s;

    typedef struct packed {
        logic        retire;
        logic        hit;
        logic        stlbMiss;
        logic        lock;
        logic [47:0] addr;
    } pslp_store_s;

    typedef struct packed {
        logic        valid;
        logic [63:0] addr;
        logic [63:0] src;
        logic [63:0] lat;
    } pslp_rec_s;

endpackage : pslp_pkg

// File: verilog/pslp_top.sv
// Behaviour
// - load-latency counter counts only tagged retired loads above limit, never stores
// - latency limit is in core cycles; only strictly greater latencies count
// - latency runs from load dispatch until data globally observable
// - loads are picked at random and tagged; their latency and source tracked
// - cancelled tagged load is not counted, state kept, next load tagged
// - record gets latency and source of last tagged load retired before; here only tagged loads above the limit update them
// - reload value only sets tagged loads between records, independent of tagging
// - source field: encoding 3:0, translation miss bit 4, lock bit 5
// - precise store capture exists only on counter 3
// - counter 3 overflow captures next retiring store address and status
// - store record: address at 98H, hit/miss/lock at A0H, A8H reserved
// - precise distribution warns before overflow and traps on exact instruction
// - after a record, clear status only for overflowed sampling-enabled counters
// - store records carry zero latency
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pslp_top (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // core events
    input  wire pslp_pkg::pslp_load_s  ld,
    input  wire pslp_pkg::pslp_store_s st,
    input  wire logic                 instRetire,
    input  wire logic [3:0]           genEvent,
    // to the core
    output logic                      ldTagReq,
    output logic                      earlyWarn,
    output logic                      preciseTrap,
    output pslp_pkg::pslp_rec_s        rec
);
    import pslp_pkg::*;

    // ==========================================================
    // registers
    logic [31:0]      evtSel_r  [NUM_CTR];
    logic [31:0]      evtSel_nxt[NUM_CTR];
    logic [CTR_W-1:0] reload_r  [NUM_CTR];
    logic [CTR_W-1:0] reload_nxt[NUM_CTR];
    logic [63:0]      sampEn_r, sampEn_nxt;
    logic [LAT_W-1:0] latLimit_r, latLimit_nxt;
    logic [3:0]       status_r, status_nxt;
    logic [CTR_W-1:0] count   [NUM_CTR];
    logic [3:0]       incVec, ovfVec, nearVec, wrCtr, llCtr, swClr, hwClr;
    logic             wrAcc, rdAcc, hit;
    logic [5:0]       wIdx;

    assign wrAcc  = psel & penable & pwrite;
    assign rdAcc  = psel & penable & !pwrite;
    assign pready = 1'b1;
    assign wIdx   = paddr[7:2];

    always_comb begin
        for (int i = 0; i < NUM_CTR; i++) begin
            evtSel_nxt[i] = evtSel_r[i];
            reload_nxt[i] = reload_r[i];
            wrCtr[i]      = 1'b0;
            if (wrAcc && paddr == OFF_EVTSEL0 + 8'(4 * i)) begin
                evtSel_nxt[i] = pwdata;
            end
            if (wrAcc && paddr == OFF_RELOAD0 + 8'(4 * i)) begin
                reload_nxt[i] = pwdata;
            end
            if (wrAcc && paddr == OFF_COUNT0 + 8'(4 * i)) begin
                wrCtr[i] = 1'b1;
            end
        end
        sampEn_nxt   = sampEn_r;
        latLimit_nxt = latLimit_r;
        swClr        = 4'h0;
        if (wrAcc && paddr == OFF_SAMP_LO) begin
            sampEn_nxt[31:0] = pwdata;
        end
        if (wrAcc && paddr == OFF_SAMP_HI) begin
            sampEn_nxt[63:32] = pwdata;
        end
        if (wrAcc && paddr == OFF_LAT_LIMIT) begin
            latLimit_nxt = pwdata[LAT_W-1:0];
        end
        if (wrAcc && paddr == OFF_STATUS) begin
            swClr = pwdata[3:0];
        end
        // a new overflow beats any clear in the same cycle
        status_nxt = (status_r & ~swClr & ~hwClr) | ovfVec;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_CTR; i++) begin
                evtSel_r[i] <= 32'h0000_0000;
                reload_r[i] <= 32'h0000_0000;
            end
            sampEn_r   <= 64'h0000_0000_0000_0000;
            latLimit_r <= 16'h0000;
            status_r   <= 4'h0;
        end else begin
            evtSel_r   <= evtSel_nxt;
            reload_r   <= reload_nxt;
            sampEn_r   <= sampEn_nxt;
            latLimit_r <= latLimit_nxt;
            status_r   <= status_nxt;
        end
    end

    // ==========================================================
    // register read
    logic [LAT_W-1:0] lastLat_r, lastLat_nxt;

    always_comb begin
        prdata = 32'h0000_0000;
        hit    = 1'b1;
        if (wIdx < 6'd4) begin
            prdata = evtSel_r[wIdx[1:0]];
        end else if (wIdx >= 6'd8 && wIdx < 6'd12) begin
            prdata = count[wIdx[1:0]];
        end else if (wIdx >= 6'd12 && wIdx < 6'd16) begin
            prdata = reload_r[wIdx[1:0]];
        end else if (paddr == OFF_SAMP_LO) begin
            prdata = sampEn_r[31:0];
        end else if (paddr == OFF_SAMP_HI) begin
            prdata = sampEn_r[63:32];
        end else if (paddr == OFF_LAT_LIMIT) begin
            prdata = {16'h0000, latLimit_r};
        end else if (paddr == OFF_STATUS) begin
            prdata = {28'h000_0000, status_r};
        end else if (paddr == OFF_LAST_LAT) begin
            prdata = {16'h0000, lastLat_r};
        end else begin
            hit = 1'b0;
        end
        if (!rdAcc) begin
            prdata = 32'h0000_0000;
        end
    end

    assign pslverr = psel & penable & !hit;

    // ==========================================================
    // facility configuration
    logic psCfg, pdCfg, llActive;

    always_comb begin
        for (int i = 0; i < NUM_CTR; i++) begin
            llCtr[i] = evtSel_r[i][15:0] == EVT_LOAD_LAT && evtSel_r[i][EVT_EN_BIT]
                       && sampEn_r[i] && sampEn_r[LL_EN_LSB + i];
        end
    end

    assign llActive = |llCtr;
    // only counter 3 can ever arm store capture
    assign psCfg = evtSel_r[STORE_CTR][15:0] == EVT_PREC_STORE
                   && evtSel_r[STORE_CTR][EVT_EN_BIT]
                   && sampEn_r[STORE_CTR] && sampEn_r[PS_EN_BIT];
    assign pdCfg = evtSel_r[PDIST_CTR][15:0] == EVT_PREC_DIST
                   && evtSel_r[PDIST_CTR][EVT_EN_BIT] && sampEn_r[PDIST_CTR];

    // ==========================================================
    // load tagging and latency measurement
    logic             rndBit, llHit;
    logic             tagBusy_r, tagBusy_nxt, tagGo_r, tagGo_nxt;
    logic             retag_r, retag_nxt;
    logic [LAT_W-1:0] latCnt_r, latCnt_nxt;
    logic [5:0]       lastSrc_r, lastSrc_nxt;
    logic [47:0]      lastAddr_r, lastAddr_nxt;

    pslp_lfsr #(.W(16), .TAPS(LFSR_TAPS), .SEED(RST_LFSR)) u_lfsr (
        .clk    (clk),
        .rst_b  (rst_b),
        .rndBit (rndBit)
    );

    // one tagged load in flight keeps the tracking state to one set
    assign ldTagReq = llActive & !tagBusy_r & (rndBit | retag_r);
    assign llHit    = tagBusy_r & ld.retire & !ld.cancel
                      & (latCnt_r > latLimit_r);

    always_comb begin
        tagBusy_nxt  = tagBusy_r;
        tagGo_nxt    = tagGo_r;
        retag_nxt    = retag_r;
        latCnt_nxt   = latCnt_r;
        lastLat_nxt  = lastLat_r;
        lastSrc_nxt  = lastSrc_r;
        lastAddr_nxt = lastAddr_r;
        if (ld.dispatch && ldTagReq) begin
            tagBusy_nxt = 1'b1;
            tagGo_nxt   = 1'b0;
            retag_nxt   = 1'b0;
            // the dispatch cycle is the first counted cycle, so go at cycle k reads k
            latCnt_nxt  = 16'h0001;
        end else if (tagBusy_r) begin
            if (!tagGo_r && !ld.go && latCnt_r != '1) begin
                latCnt_nxt = latCnt_r + 16'h0001;
            end
            if (ld.go) begin
                tagGo_nxt = 1'b1;
            end
            if (ld.cancel) begin
                tagBusy_nxt = 1'b0;
                retag_nxt   = 1'b1;
            end else if (ld.retire) begin
                tagBusy_nxt = 1'b0;
                if (llHit) begin
                    lastLat_nxt  = latCnt_r;
                    lastSrc_nxt  = {ld.lock, ld.stlbMiss, ld.source};
                    lastAddr_nxt = ld.addr;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tagBusy_r  <= 1'b0;
            tagGo_r    <= 1'b0;
            retag_r    <= 1'b0;
            latCnt_r   <= 16'h0000;
            lastLat_r  <= 16'h0000;
            lastSrc_r  <= 6'h00;
            lastAddr_r <= 48'h0000_0000_0000;
        end else begin
            tagBusy_r  <= tagBusy_nxt;
            tagGo_r    <= tagGo_nxt;
            retag_r    <= retag_nxt;
            latCnt_r   <= latCnt_nxt;
            lastLat_r  <= lastLat_nxt;
            lastSrc_r  <= lastSrc_nxt;
            lastAddr_r <= lastAddr_nxt;
        end
    end

    // ==========================================================
    // counters
    always_comb begin
        for (int i = 0; i < NUM_CTR; i++) begin
            incVec[i] = 1'b0;
            if (evtSel_r[i][EVT_EN_BIT]) begin
                unique case (evtSel_r[i][15:0])
                    EVT_LOAD_LAT:   incVec[i] = llCtr[i] & llHit;
                    EVT_PREC_STORE: incVec[i] = (i == STORE_CTR) & st.retire;
                    EVT_PREC_DIST:  incVec[i] = (i == PDIST_CTR) & instRetire;
                    default:        incVec[i] = genEvent[i];
                endcase
            end
        end
    end

    for (genvar g = 0; g < NUM_CTR; g++) begin : g_ctr
        pslp_counter #(.W(CTR_W)) u_ctr (
            .clk       (clk),
            .rst_b     (rst_b),
            .inc       (incVec[g]),
            .wrEn      (wrCtr[g]),
            .wrVal     (pwdata),
            .reloadEn  (sampEn_r[g]),
            .reloadVal (reload_r[g]),
            .count     (count[g]),
            .ovf       (ovfVec[g]),
            .nearOvf   (nearVec[g])
        );
    end

    // ==========================================================
    // assist and record write
    pslp_asst_e state_r, state_nxt;
    pslp_rec_s  rec_r, rec_nxt;
    logic       recStore_r, recStore_nxt, trap_r, trap_nxt;
    logic [3:0] samplOvf;

    assign samplOvf = ovfVec & sampEn_r[3:0];
    assign hwClr    = rec_r.valid ? (status_r & sampEn_r[3:0]) : 4'h0;
    assign earlyWarn = pdCfg & nearVec[PDIST_CTR];
    // overflows arriving while a store is awaited set status and write no record; a precise distribution overflow still traps
    always_comb begin
        state_nxt    = state_r;
        rec_nxt      = rec_r;
        rec_nxt.valid = 1'b0;
        recStore_nxt = recStore_r;
        trap_nxt     = ovfVec[PDIST_CTR] & pdCfg;
        unique case (state_r)
            AS_IDLE: begin
                if (samplOvf[STORE_CTR] && psCfg) begin
                    state_nxt = AS_WAIT_ST;
                end else if (|samplOvf) begin
                    rec_nxt.valid = 1'b1;
                    // a load retiring on the overflow edge is the one sampled
                    rec_nxt.addr  = {16'h0000, lastAddr_nxt};
                    rec_nxt.src   = {58'h0, lastSrc_nxt};
                    rec_nxt.lat   = {48'h0, lastLat_nxt};
                    recStore_nxt  = 1'b0;
                end
            end
            AS_WAIT_ST: begin
                if (st.retire) begin
                    state_nxt     = AS_IDLE;
                    rec_nxt.valid = 1'b1;
                    rec_nxt.addr  = {16'h0000, st.addr};
                    rec_nxt.src   = 64'h0;
                    rec_nxt.src[ST_HIT_BIT]   = st.hit;
                    rec_nxt.src[SRC_STLB_BIT] = st.stlbMiss;
                    rec_nxt.src[SRC_LOCK_BIT] = st.lock;
                    rec_nxt.lat   = 64'h0;
                    recStore_nxt  = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r    <= AS_IDLE;
            rec_r      <= '0;
            recStore_r <= 1'b0;
            trap_r     <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            rec_r      <= rec_nxt;
            recStore_r <= recStore_nxt;
            trap_r     <= trap_nxt;
        end
    end

    assign rec         = rec_r;
    assign preciseTrap = trap_r;

    // ==========================================================
    // checks
    a_tag_when_free: assert property (@(posedge clk) disable iff (!rst_b)
        ldTagReq |-> !tagBusy_r && llActive) else $error("tag while busy");
    a_cancel_retag: assert property (@(posedge clk) disable iff (!rst_b)
        tagBusy_r && ld.cancel |=> retag_r && !tagBusy_r && $stable(lastLat_r))
        else $error("cancel mishandled");
    a_lat_count: assert property (@(posedge clk) disable iff (!rst_b)
        (ld.dispatch && ldTagReq) ##1 (!ld.go && !ld.cancel && !ld.retire)[*3]
        |-> latCnt_r == 16'd3) else $error("latency count off");
    a_lat_strict: assert property (@(posedge clk) disable iff (!rst_b)
        tagBusy_r && ld.retire && latCnt_r <= latLimit_r |=> $stable(lastLat_r))
        else $error("latency at limit used");
    a_ll_count_only: assert property (@(posedge clk) disable iff (!rst_b)
        llCtr[0] && incVec[0] |-> llHit) else $error("stray load count");
    a_ll_record: assert property (@(posedge clk) disable iff (!rst_b)
        state_r == AS_IDLE && |samplOvf && !(samplOvf[STORE_CTR] && psCfg)
        |=> rec_r.valid && rec_r.lat[15:0] == $past(lastLat_nxt))
        else $error("record latency wrong");
    a_src_layout: assert property (@(posedge clk) disable iff (!rst_b)
        rec_r.valid |-> rec_r.src[63:6] == 58'h0) else $error("reserved set");
    a_store_zero: assert property (@(posedge clk) disable iff (!rst_b)
        rec_r.valid && recStore_r |-> rec_r.lat == 64'h0) else $error("store lat");
    a_store_addr: assert property (@(posedge clk) disable iff (!rst_b)
        state_r == AS_WAIT_ST && st.retire
        |=> rec_r.valid && rec_r.addr[47:0] == $past(st.addr))
        else $error("store address lost");
    a_store_ctr3: assert property (@(posedge clk) disable iff (!rst_b)
        state_r == AS_IDLE && !samplOvf[STORE_CTR] |=> state_r == AS_IDLE)
        else $error("store capture off counter 3");
    a_pdist_trap: assert property (@(posedge clk) disable iff (!rst_b)
        ovfVec[PDIST_CTR] && pdCfg |-> earlyWarn ##1 preciseTrap)
        else $error("no precise trap");
    a_status_clear: assert property (@(posedge clk) disable iff (!rst_b)
        rec_r.valid && ovfVec == 4'h0 && !(wrAcc && paddr == OFF_STATUS)
        |=> status_r == ($past(status_r) & ~$past(sampEn_r[3:0])))
        else $error("status clear wrong");
    c_ll_record: cover property (@(posedge clk) disable iff (!rst_b)
        rec_r.valid && !recStore_r && rec_r.lat != 64'h0);
    c_store_record: cover property (@(posedge clk) disable iff (!rst_b)
        rec_r.valid && recStore_r);
    c_pdist_trap: cover property (@(posedge clk) disable iff (!rst_b) preciseTrap);
endmodule : pslp_top
`default_nettype wire
